// ### src/frame_codec_cfg.svh
// Purpose: Framing constants for the host command frame codec
// Assumes: 8-bit characters, one clock domain
// Notes:   Definitions only
`ifndef FRAME_CODEC_CFG_SVH
`define FRAME_CODEC_CFG_SVH

`define FC_SOH       8'h01
`define FC_LF        8'h0A
`define FC_CR        8'h0D
`define FC_CODE_LEN  3'h4
`define FC_HELD_FULL 2'h2
`define FC_ASCII_0   8'h30
`define FC_ASCII_UA  8'h41
`define FC_ASCII_LA  8'h61
`define FC_NIB_TEN   4'hA
`define FC_DEC_SPAN  8'h09
`define FC_HEX_SPAN  8'h05
`define FC_CODE_LAST 2'h3

`endif

// ### src/frame_codec_pkg.sv
// Purpose: Types shared by the frame codec modules
// Assumes: frame_codec_cfg.svh holds the numeric constants
// Notes:   States carry no explicit codes
package frame_codec_pkg;

	typedef enum logic [1:0] {RX_HUNT, RX_BODY, RX_LFWAIT} rx_state_t;

	typedef enum logic [2:0] {TX_IDLE, TX_SOH, TX_CODE, TX_DATA, TX_FCS_HI, TX_FCS_LO, TX_CR, TX_LF} tx_state_t;

endpackage

// ### src/fcs_char_codec.sv
// Purpose: Frame check value to/from two ASCII hex characters
// Assumes: Purely combinational
// Notes:   Encodes upper case, decodes either case
`timescale 1ns/1ps
`include "frame_codec_cfg.svh"

module fcs_char_codec
	import frame_codec_pkg::*;
(
	input  wire logic [7:0] i_enc_byte,
	output logic      [7:0] o_enc_hi,
	output logic      [7:0] o_enc_lo,
	input  wire logic [7:0] i_dec_hi,
	input  wire logic [7:0] i_dec_lo,
	output logic      [7:0] o_dec_byte,
	output logic            o_dec_ok
);

	// Bit 4 is the valid flag, low nibble the value
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h00;
		if (c >= `FC_ASCII_0 && c <= `FC_ASCII_0 + `FC_DEC_SPAN)
			r = {1'b1, 4'(c - `FC_ASCII_0)};
		else if (c >= `FC_ASCII_UA && c <= `FC_ASCII_UA + `FC_HEX_SPAN)
			r = {1'b1, 4'(c - `FC_ASCII_UA) + `FC_NIB_TEN};
		else if (c >= `FC_ASCII_LA && c <= `FC_ASCII_LA + `FC_HEX_SPAN)
			r = {1'b1, 4'(c - `FC_ASCII_LA) + `FC_NIB_TEN};
		return r;
	endfunction

	wire logic [7:0] enc [2];

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_nib
			wire logic [3:0] nib = i_enc_byte[4*g +: 4];
			assign enc[g] = (nib < `FC_NIB_TEN) ? (`FC_ASCII_0 + {4'h0, nib})
				: (`FC_ASCII_UA + {4'h0, nib - `FC_NIB_TEN});
		end
	endgenerate

	wire logic [4:0] dh = hex_val(i_dec_hi);
	wire logic [4:0] dl = hex_val(i_dec_lo);

	assign o_enc_lo   = enc[0];
	assign o_enc_hi   = enc[1];
	assign o_dec_byte = {dh[3:0], dl[3:0]};
	assign o_dec_ok   = dh[4] & dl[4];

endmodule // fcs_char_codec

// ### src/host_command_frame_codec.sv
// Purpose: Checks host command frames and builds response frames
// Assumes: Byte streams synchronous to i_mclk; link type on i_link_serial
// Notes:   Command data is streamed as it arrives; the end pulse decides
//          whether the consumer keeps or drops what it received
`timescale 1ns/1ps
`include "frame_codec_cfg.svh"

module host_command_frame_codec
	import frame_codec_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_link_serial,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_data,
	output logic      [31:0] o_cmd_code,
	output logic             o_cmd_data_valid,
	output logic      [7:0]  o_cmd_data,
	output logic             o_cmd_done,
	output logic             o_cmd_fcs_err,
	output logic             o_cmd_fmt_err,
	input  wire logic        i_rsp_start,
	input  wire logic        i_rsp_valid,
	input  wire logic [7:0]  i_rsp_data,
	input  wire logic        i_rsp_last,
	output logic             o_rsp_ready,
	output logic             o_tx_busy,
	output logic             o_tx_valid,
	output logic      [7:0]  o_tx_data,
	input  wire logic        i_tx_ready
);

	rx_state_t   rx_st_ff;
	logic [2:0]  code_idx_ff;
	logic [31:0] code_sr_ff;
	logic [31:0] code_ff;
	logic [7:0]  rx_acc_ff;
	logic [7:0]  held0_ff;
	logic [7:0]  held1_ff;
	logic [1:0]  held_cnt_ff;
	logic        fcs_ok_ff;
	logic        dvalid_ff;
	logic [7:0]  ddata_ff;
	logic        done_ff;
	logic        fcs_err_ff;
	logic        fmt_err_ff;

	wire logic [7:0] dec_byte;
	wire logic       dec_ok;
	wire logic [7:0] enc_hi;
	wire logic [7:0] enc_lo;
	logic      [7:0] tx_acc_ff;

	fcs_char_codec u_fcs
	(
		.i_enc_byte (tx_acc_ff),
		.o_enc_hi   (enc_hi),
		.o_enc_lo   (enc_lo),
		.i_dec_hi   (held1_ff),
		.i_dec_lo   (held0_ff),
		.o_dec_byte (dec_byte),
		.o_dec_ok   (dec_ok)
	);

	// Receive decode
	wire logic is_lf   = (i_rx_data == `FC_LF);
	wire logic is_cr   = (i_rx_data == `FC_CR);
	wire logic is_soh  = (i_rx_data == `FC_SOH);
	wire logic in_body = i_rx_valid && (rx_st_ff == RX_BODY || (rx_st_ff == RX_HUNT && !i_link_serial));
	wire logic ser_body = in_body && i_link_serial;
	wire logic net_body = in_body && !i_link_serial;
	wire logic code_full = (code_idx_ff == `FC_CODE_LEN);
	wire logic held_full = (held_cnt_ff == `FC_HELD_FULL);
	// Serial holds back two characters since they may turn out to be the check pair
	wire logic ser_emit = ser_body && !is_cr && !is_lf && held_full;
	wire logic net_emit = net_body && !is_lf;
	wire logic emit_en  = ser_emit || net_emit;
	wire logic [7:0] emit_byte = i_link_serial ? held1_ff : i_rx_data;
	wire logic ser_cr   = ser_body && is_cr;
	wire logic ser_lf   = ser_body && is_lf;
	wire logic net_lf   = net_body && is_lf;
	wire logic lfw      = i_rx_valid && rx_st_ff == RX_LFWAIT;
	wire logic lfw_good = lfw && is_lf && fcs_ok_ff && code_full;
	wire logic end_frame = ser_cr ? !held_full : (ser_lf || net_lf || lfw);
	wire logic good_end = net_lf ? code_full : lfw_good;
	wire logic fcs_bad  = lfw && is_lf && !fcs_ok_ff && code_full;
	wire logic fmt_bad  = end_frame && !good_end && !fcs_bad;
	wire rx_state_t idle_st = i_link_serial ? RX_HUNT : RX_BODY;

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			rx_st_ff <= RX_HUNT;
		else if (rx_st_ff == RX_HUNT && i_link_serial && i_rx_valid && is_soh)
			rx_st_ff <= RX_BODY;
		else if (ser_cr && held_full)
			rx_st_ff <= RX_LFWAIT;
		else if (end_frame)
			rx_st_ff <= idle_st;
		else if (net_emit)
			rx_st_ff <= RX_BODY;
	end

	// Last two held chars are the check pair
	always_ff @(posedge i_mclk)
	begin
		if (i_reset || end_frame || (rx_st_ff == RX_HUNT && i_link_serial))
		begin
			held_cnt_ff <= 2'h0;
			held0_ff    <= 8'h00;
			held1_ff    <= 8'h00;
		end
		else if (ser_body && !is_cr && !is_lf)
		begin
			held0_ff    <= i_rx_data;
			held1_ff    <= held0_ff;
			held_cnt_ff <= held_full ? held_cnt_ff : held_cnt_ff + 2'h1;
		end
	end

	// Compare received pair with local parity
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			fcs_ok_ff <= 1'b0;
		else if (ser_cr)
			fcs_ok_ff <= dec_ok && (dec_byte == rx_acc_ff);
	end

	// First four characters form the code
	always_ff @(posedge i_mclk)
	begin
		if (i_reset || end_frame || (rx_st_ff == RX_HUNT && i_link_serial))
		begin
			code_idx_ff <= 3'h0;
			code_sr_ff  <= 32'h0000_0000;
			rx_acc_ff   <= 8'h00;
		end
		else if (emit_en)
		begin
			rx_acc_ff <= rx_acc_ff ^ emit_byte;
			if (!code_full)
			begin
				code_sr_ff  <= {code_sr_ff[23:0], emit_byte};
				code_idx_ff <= code_idx_ff + 3'h1;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			dvalid_ff  <= 1'b0;
			ddata_ff   <= 8'h00;
			done_ff    <= 1'b0;
			fcs_err_ff <= 1'b0;
			fmt_err_ff <= 1'b0;
			code_ff    <= 32'h0000_0000;
		end
		else
		begin
			dvalid_ff  <= emit_en && code_full;
			ddata_ff   <= emit_en ? emit_byte : ddata_ff;
			done_ff    <= end_frame && good_end;
			fcs_err_ff <= fcs_bad;
			fmt_err_ff <= fmt_bad;
			// Only an accepted frame replaces the code that responses repeat
			if (end_frame && good_end)
				code_ff <= code_sr_ff;
		end
	end

	assign o_cmd_code       = code_ff;
	assign o_cmd_data_valid = dvalid_ff;
	assign o_cmd_data       = ddata_ff;
	assign o_cmd_done       = done_ff;
	assign o_cmd_fcs_err    = fcs_err_ff;
	assign o_cmd_fmt_err    = fmt_err_ff;

	// Response transmitter
	tx_state_t  tx_st_ff;
	logic       tx_ser_ff;
	logic [1:0] tx_idx_ff;
	logic       tvalid_ff;
	logic [7:0] tdata_ff;

	wire logic adv      = !tvalid_ff || i_tx_ready;
	wire logic [7:0] code_ch = code_ff[8*(`FC_CODE_LAST - tx_idx_ff) +: 8];
	wire logic take_rsp = (tx_st_ff == TX_DATA) && adv && i_rsp_valid;
	// A data slot waits for the producer; every framing slot loads on its own
	wire logic load     = take_rsp || (adv && tx_st_ff != TX_IDLE && tx_st_ff != TX_DATA);
	wire logic last_code = (tx_idx_ff == `FC_CODE_LAST);
	logic [7:0] nxt_tdata;
	tx_state_t  nxt_tx_st;

	always_comb
	begin
		nxt_tdata = tdata_ff;
		nxt_tx_st = tx_st_ff;
		case (tx_st_ff)
			TX_IDLE:
				if (i_rsp_start)
					nxt_tx_st = i_link_serial ? TX_SOH : TX_CODE;
			TX_SOH:
			begin
				nxt_tdata = `FC_SOH;
				nxt_tx_st = TX_CODE;
			end
			TX_CODE:
			begin
				nxt_tdata = code_ch;
				nxt_tx_st = last_code ? TX_DATA : TX_CODE;
			end
			TX_DATA:
			begin
				nxt_tdata = i_rsp_data;
				if (i_rsp_last)
					nxt_tx_st = tx_ser_ff ? TX_FCS_HI : TX_LF;
			end
			TX_FCS_HI:
			begin
				nxt_tdata = enc_hi;
				nxt_tx_st = TX_FCS_LO;
			end
			TX_FCS_LO:
			begin
				nxt_tdata = enc_lo;
				nxt_tx_st = TX_CR;
			end
			TX_CR:
			begin
				nxt_tdata = `FC_CR;
				nxt_tx_st = TX_LF;
			end
			TX_LF:
			begin
				nxt_tdata = `FC_LF;
				nxt_tx_st = TX_IDLE;
			end
			default:
				nxt_tx_st = TX_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			tx_st_ff  <= TX_IDLE;
			tx_ser_ff <= 1'b0;
			tx_idx_ff <= 2'h0;
			tvalid_ff <= 1'b0;
			tdata_ff  <= 8'h00;
			tx_acc_ff <= 8'h00;
		end
		else
		begin
			if (tx_st_ff == TX_IDLE)
			begin
				tx_ser_ff <= i_link_serial;
				tx_idx_ff <= 2'h0;
				tx_acc_ff <= 8'h00;
			end
			if (tx_st_ff == TX_IDLE || load)
				tx_st_ff <= nxt_tx_st;
			if (load)
			begin
				tdata_ff <= nxt_tdata;
				if (tx_st_ff == TX_CODE)
					tx_idx_ff <= tx_idx_ff + 2'h1;
				if (tx_st_ff == TX_CODE || tx_st_ff == TX_DATA)
					tx_acc_ff <= tx_acc_ff ^ nxt_tdata;
			end
			if (adv)
				tvalid_ff <= load;
		end
	end

	assign o_rsp_ready = (tx_st_ff == TX_DATA) && adv;
	assign o_tx_busy   = (tx_st_ff != TX_IDLE);
	assign o_tx_valid  = tvalid_ff;
	assign o_tx_data   = tdata_ff;

endmodule // host_command_frame_codec

// ### tb/frame_codec_checker.sv
// Purpose: Port assertions for the frame codec
// Assumes: One clock, synchronous reset
// Notes:   Response data never holds CR, LF or SOH
`timescale 1ns/1ps
module frame_codec_checker
	import frame_codec_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_link_serial,
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic [31:0] o_cmd_code,
	input  wire logic        o_cmd_done,
	input  wire logic        o_cmd_fcs_err,
	input  wire logic        o_cmd_fmt_err,
	input  wire logic        i_rsp_start,
	input  wire logic        o_rsp_ready,
	input  wire logic        o_tx_busy,
	input  wire logic        o_tx_valid,
	input  wire logic [7:0]  o_tx_data,
	input  wire logic        i_tx_ready
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	a_tx_first_char: assert property (i_rsp_start && !o_tx_busy |-> ##2 o_tx_valid &&
		o_tx_data == (i_link_serial ? 8'h01 : o_cmd_code[31:24])) else $error("wrong first response char");
	a_tx_hold_char: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("response char dropped in stall");
	a_tx_cr_lf: assert property (o_tx_valid && i_tx_ready && o_tx_data == 8'h0D |=>
		o_tx_valid && o_tx_data == 8'h0A) else $error("CR not followed by LF");
	a_tx_lf_closes: assert property (o_tx_valid && i_tx_ready && o_tx_data == 8'h0A |=>
		!o_tx_busy && !o_tx_valid) else $error("frame goes on after LF");
	a_net_plain_frame: assert property (o_tx_valid && !i_link_serial |->
		o_tx_data != 8'h0D && o_tx_data != 8'h01) else $error("serial framing on network");
	a_done_on_lf: assert property (o_cmd_done |-> $past(i_rx_valid && i_rx_data == 8'h0A))
		else $error("frame accepted without LF");
	a_one_verdict: assert property ($onehot0({o_cmd_done, o_cmd_fcs_err, o_cmd_fmt_err}))
		else $error("two frame verdicts at once");
	a_code_steady: assert property (!o_cmd_done |-> $stable(o_cmd_code))
		else $error("command code moved without done");
	a_ready_in_frame: assert property (o_rsp_ready |-> o_tx_busy && $past(o_tx_busy, 4))
		else $error("response taken before code echoed");
	a_fcs_serial_only: assert property (o_cmd_fcs_err |-> i_link_serial)
		else $error("check error on network link");
endmodule // frame_codec_checker
bind host_command_frame_codec frame_codec_checker chk (.*);

// ### tb/host_link_model.sv
// Purpose: Host side of the link: sends command frames, sinks responses
// Assumes: Kind 0 good, 1 bad check, 2 CR missing, 3 lower-case check
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/1ps
module host_link_model (
	input  wire logic       i_mclk,
	input  wire logic       i_slow,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	output logic            o_tx_ready = 1'b1,
	output logic            o_rx_valid = 1'b0,
	output logic      [7:0] o_rx_data = 8'h00
);
	logic [7:0] cap[$];
	always @(posedge i_mclk)
	begin
		if (i_tx_valid && o_tx_ready)
			cap.push_back(i_tx_data);
		o_tx_ready <= !i_slow || !o_tx_ready;
	end
	function automatic logic [7:0] hx(input logic [3:0] n, input bit lc);
		return (n < 4'hA) ? 8'h30 + n : (lc ? 8'h57 : 8'h37) + n;
	endfunction
	task automatic put(input logic [7:0] c);
		@(posedge i_mclk);
		o_rx_valid <= 1'b1;
		o_rx_data <= c;
	endtask
	task automatic send(input bit ser, input string b, input int kind);
		logic [7:0] x;
		x = 8'h00;
		if (ser)
			put(8'h01);
		foreach (b[i])
		begin
			put(b[i]);
			x ^= b[i];
		end
		if (kind == 1)
			x = ~x;
		if (ser)
		begin
			put(hx(x[7:4], kind == 3));
			put(hx(x[3:0], kind == 3));
			if (kind != 2)
				put(8'h0D);
		end
		put(8'h0A);
		@(posedge i_mclk);
		o_rx_valid <= 1'b0;
		// Released line shows the inverse, not a stale copy
		o_rx_data <= ~o_rx_data;
	endtask
endmodule // host_link_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the frame codec
// Assumes: Host model drives the receive side
// Notes:   Rows cover receive verdicts; responses are hand-written
`timescale 1ns/1ps
module tb_top;
	typedef struct {bit ser; string b; int kind; logic [2:0] exp;} row_t;
	logic        i_mclk = 0, i_reset = 1, i_link_serial = 1, slow = 0;
	logic        i_rsp_start = 0, i_rsp_valid = 0, i_rsp_last = 0;
	logic [7:0]  i_rsp_data = 8'h00, o_cmd_data, o_tx_data, i_rx_data;
	logic [31:0] o_cmd_code;
	logic        o_cmd_data_valid, o_cmd_done, o_cmd_fcs_err, o_cmd_fmt_err;
	logic        o_rsp_ready, o_tx_busy, o_tx_valid, i_tx_ready, i_rx_valid;
	logic [2:0]  res;
	logic [7:0]  dq[$];
	int          n_errors = 0, compares = 0;
	row_t rows[8] = '{'{1, "RDID -ant 1", 0, 3'h4}, '{1, "WTDT 12", 1, 3'h2}, '{1, "SETR x", 2, 3'h1},
		'{1, "RDID0", 3, 3'h4}, '{1, "AB", 0, 3'h1}, '{0, "GETC", 0, 3'h4}, '{0, "AB", 0, 3'h1},
		'{0, "SAVE 9", 0, 3'h4}};
	host_command_frame_codec dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_link_serial(i_link_serial),
		.i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_cmd_code(o_cmd_code),
		.o_cmd_data_valid(o_cmd_data_valid), .o_cmd_data(o_cmd_data), .o_cmd_done(o_cmd_done),
		.o_cmd_fcs_err(o_cmd_fcs_err), .o_cmd_fmt_err(o_cmd_fmt_err), .i_rsp_start(i_rsp_start),
		.i_rsp_valid(i_rsp_valid), .i_rsp_data(i_rsp_data), .i_rsp_last(i_rsp_last),
		.o_rsp_ready(o_rsp_ready), .o_tx_busy(o_tx_busy), .o_tx_valid(o_tx_valid),
		.o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready));
	host_link_model host (.i_mclk(i_mclk), .i_slow(slow), .i_tx_valid(o_tx_valid),
		.i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));
	initial
	begin
		forever #25 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
	begin
		if (o_cmd_data_valid)
			dq.push_back(o_cmd_data);
		if (o_cmd_done | o_cmd_fcs_err | o_cmd_fmt_err)
			res = {o_cmd_done, o_cmd_fcs_err, o_cmd_fmt_err};
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic end_sim;
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic rsp(input bit ser, input string d);
		byte unsigned e[$];
		string s;
		logic [7:0] x;
		int i, n;
		s = {"SAVE", d};
		x = 8'h00;
		i = 0;
		n = 0;
		host.cap.delete();
		slow <= ser;
		i_link_serial <= ser;
		@(posedge i_mclk);
		i_rsp_start <= 1'b1;
		// Second start edge lands while busy and must be ignored
		repeat (2) @(posedge i_mclk);
		i_rsp_start <= 1'b0;
		i_rsp_valid <= 1'b1;
		i_rsp_data <= d[0];
		i_rsp_last <= (d.len() == 1);
		while (i < d.len() && n < 200)
		begin
			@(posedge i_mclk);
			n++;
			if (o_rsp_ready)
			begin
				i++;
				i_rsp_data <= d[i];
				i_rsp_last <= (i == d.len() - 1);
			end
		end
		i_rsp_valid <= 1'b0;
		// The closing LF may still wait for the sink after the state goes idle
		while ((o_tx_busy || o_tx_valid) && n < 200)
		begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= 200)
			n_errors++;
		if (ser)
			e.push_back(8'h01);
		foreach (s[k])
		begin
			e.push_back(s[k]);
			x ^= s[k];
		end
		if (ser)
			e = {e, host.hx(x[7:4], 0), host.hx(x[3:0], 0), 8'h0D};
		e.push_back(8'h0A);
		chk(host.cap.size(), e.size());
		foreach (e[k])
			chk(host.cap[k], e[k]);
	endtask
	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_reset <= 1'b0;
		chk(o_cmd_code, 32'h0);
		foreach (rows[r])
		begin
			i_link_serial <= rows[r].ser;
			res = 3'h0;
			dq.delete();
			host.send(rows[r].ser, rows[r].b, rows[r].kind);
			repeat (3) @(posedge i_mclk);
			chk(res, rows[r].exp);
			if (rows[r].exp == 3'h4)
			begin
				chk(o_cmd_code, {rows[r].b[0], rows[r].b[1], rows[r].b[2], rows[r].b[3]});
				chk(dq.size(), rows[r].b.len() - 4);
				foreach (dq[i])
					chk(dq[i], rows[r].b[i + 4]);
			end
		end
		rsp(1, "OK");
		rsp(0, "Z");
		// Reset in mid-run clears outputs, then a network frame is taken at once
		i_reset <= 1'b1;
		repeat (3) @(posedge i_mclk);
		chk(o_cmd_code, 32'h0);
		chk({o_tx_busy, o_tx_valid, o_cmd_done, o_cmd_data_valid}, 32'h0);
		i_reset <= 1'b0;
		res = 3'h0;
		dq.delete();
		host.send(0, "INIT", 0);
		repeat (3) @(posedge i_mclk);
		chk(res, 3'h4);
		chk(o_cmd_code, "INIT");
		chk(dq.size(), 0);
		end_sim();
	end
	initial
	begin
		#(6000 * 50);
		n_errors++;
		end_sim();
	end
endmodule // tb_top
